/* File: rtl/tdcc_pkg.sv */
/*
 * Constants for the 8-bit timer with event counting and input capture:
 * register indices, field positions, reset values and timing counts.
 * Assumes a 32-bit AHB-Lite slave port where each register takes one word.
 */
package tdcc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CLOCK_MODE   = 8'h18;
	localparam logic [7:0] IDX_EDGE_CAPTURE = 8'h19;
	localparam logic [7:0] IDX_DIGIT_LOW    = 8'h1A;
	localparam logic [7:0] IDX_DIGIT_HIGH   = 8'h1B;
	localparam logic [7:0] IDX_PIN_FUNCTION = 8'h20;
	localparam logic [7:0] IDX_FLAGS        = 8'h21;
	localparam logic [7:0] IDX_INT_STATUS   = 8'h22;
	localparam logic [7:0] IDX_INT_MASK     = 8'h23;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CM_RELOAD_BIT   = 3;
	localparam int EC_CAPTURE_BIT  = 2;
	localparam int FLAG_IRQ_BIT    = 0;
	localparam int FLAG_CSF_BIT    = 1;
	localparam int FLAG_CEF_BIT    = 2;
	localparam int EV_OVERFLOW_BIT = 0;
	localparam int EV_CAPTURE_BIT  = 1;
	localparam int EV_CAP_ERR_BIT  = 2;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_EXTERNAL   = 3'h7;
	localparam logic [1:0] EDGE_NONE      = 2'h0;
	localparam logic [1:0] EDGE_FALLING   = 2'h1;
	localparam logic [1:0] EDGE_RISING    = 2'h2;
	localparam logic [1:0] EDGE_BOTH      = 2'h3;
	localparam logic [3:0] CLOCK_MODE_RST = 4'h0;
	localparam logic [2:0] EDGE_CAP_RST   = 3'h0;
	localparam logic [3:0] DIGIT_RST      = 4'h0;
	localparam logic [7:0] COUNT_MAX      = 8'hFF;
	localparam logic [7:0] COUNT_ZERO     = 8'h00;

	// ----------------------------------------------------------------
	// Timing: prescaler periods in instruction cycles (one hclk each)
	// ----------------------------------------------------------------
	localparam int          PRESC_W    = 11;
	localparam logic [10:0] PERIOD_M1_0 = 11'h7FF; // 2048 cycles
	localparam logic [10:0] PERIOD_M1_1 = 11'h1FF; // 512
	localparam logic [10:0] PERIOD_M1_2 = 11'h07F; // 128
	localparam logic [10:0] PERIOD_M1_3 = 11'h01F; // 32
	localparam logic [10:0] PERIOD_M1_4 = 11'h007; // 8
	localparam logic [10:0] PERIOD_M1_5 = 11'h003; // 4
	localparam logic [10:0] PERIOD_M1_6 = 11'h001; // 2
	localparam int          MODE_DELAY_INSTR = 2;  // instructions before a mode write acts
	localparam logic [1:0]  MODE_DELAY_CYC   = 2'(MODE_DELAY_INSTR);

endpackage : tdcc_pkg

/* File: rtl/tdcc_timer.sv */
/*
 * 8-bit up-counter with free-running/reload timing, external event
 * counting and input capture, behind an AHB-Lite slave with one word per
 * register. Assumes a single-master bus, single word transfers, and an
 * event pin that is asynchronous to hclk.
 */
// Functional notes
// R01: Counter starts at write value, counts clocks
// R02: Overflow at FF reloads or restarts
// R03: Overflow sets interrupt flag until cleared
// R04: Clock code external selects event counting
// R05: Count configured pin edges, otherwise same
// R06: Source keeps two cycles between edges
// R07: Capture edge stores count, flags, clears
// R08: Second trigger or overflow sets error
// R09: Capture flags clear on reset, write zero
// R10: Entering capture mode clears the counter
// R11: Software uses internal clock for capture
// R12: Clock mode change acts two cycles later
// R13: Low three bits choose prescaler period
// R14: Bit three picks reload, register resets
// R15: Edge/capture register three bits, resets zero
// R16: Write digits: low resets zero
// R17: Captured digits read in any order
// R18: Counter loads whole value on upper write
// R19: Pin synchronised, one event per edge
`timescale 1ns/1ps

module tdcc_timer
	import tdcc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        event_trigger_pin,
	output logic             irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [3:0]  clock_mode_r;      // active clock source and reload bit
	logic [3:0]  clock_pend_r;      // written value waiting to act
	logic [1:0]  mode_dly_r;        // cycles left before pending value acts
	logic [2:0]  edge_cap_r;
	logic [3:0]  digit_low_r;
	logic [3:0]  digit_high_r;
	logic        pin_function_r;
	logic [7:0]  count_r;
	logic [7:0]  capture_r;
	logic        timer_irq_flag_r;
	logic        capture_status_flag_r;
	logic        capture_error_flag_r;
	logic [2:0]  int_status_r;
	logic [2:0]  int_mask_r;
	logic [10:0] presc_r;
	logic [2:0]  pin_sync_r;
	logic        pin_level_r;
	logic        wr_pend_r;
	logic [7:0]  wr_idx_r;
	logic [31:0] hrdata_r;

	logic        bus_take;
	logic        rd_take;
	logic [7:0]  addr_idx;
	logic        wr_data;
	logic [10:0] period_m1;
	logic        presc_tick;
	logic        pin_rise;
	logic        pin_fall;
	logic        pin_edge;
	logic        capture_on;
	logic        ext_source;
	logic        count_tick;
	logic        overflow;
	logic        capture_evt;
	logic        cap_err_evt;
	logic        capture_enter;
	logic        upper_write;
	logic [2:0]  events;
	logic        int_read;

	// ----------------------------------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign bus_take  = hsel & hready & htrans[1];
	assign rd_take   = bus_take & ~hwrite;
	assign addr_idx  = haddr[9:2];
	assign wr_data   = wr_pend_r;
	assign int_read  = rd_take & (addr_idx == IDX_INT_STATUS);

	// Address phase of a write is held for its data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 8'h00;
		end
		else
		begin
			wr_pend_r <= bus_take & hwrite;
			if (bus_take)
				wr_idx_r <= addr_idx;
		end
	end

	// Read data registered at the address phase, so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 32'h0000_0000;
		else if (rd_take)
		begin
			unique case (addr_idx)
				// Capture mode reads the frozen capture, so digit order is free
				IDX_DIGIT_LOW:  hrdata_r <= {28'h0, capture_on ? capture_r[3:0] : count_r[3:0]}; // R17
				IDX_DIGIT_HIGH: hrdata_r <= {28'h0, capture_on ? capture_r[7:4] : count_r[7:4]}; // R17
				IDX_PIN_FUNCTION: hrdata_r <= {31'h0, pin_function_r};
				IDX_FLAGS:      hrdata_r <= {29'h0, capture_error_flag_r, capture_status_flag_r,
					timer_irq_flag_r};
				IDX_INT_STATUS: hrdata_r <= {29'h0, int_status_r};
				IDX_INT_MASK:   hrdata_r <= {29'h0, int_mask_r};
				default:        hrdata_r <= 32'h0000_0000; // Mode and write registers are write-only
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode and write registers
	// ----------------------------------------------------------------
	// Clock mode write waits two cycles before it acts, so code that
	// follows the write still runs under the old source
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clock_mode_r <= CLOCK_MODE_RST; // R14
			clock_pend_r <= CLOCK_MODE_RST;
			mode_dly_r   <= 2'h0;
		end
		else if (wr_data && wr_idx_r == IDX_CLOCK_MODE)
		begin
			clock_pend_r <= hwdata[3:0];
			mode_dly_r   <= MODE_DELAY_CYC; // R12
		end
		else if (mode_dly_r != 2'h0)
		begin
			mode_dly_r <= mode_dly_r - 2'h1;
			if (mode_dly_r == 2'h1)
				clock_mode_r <= clock_pend_r; // R12
		end
	end

	// Edge/capture mode, pin function and write digits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			edge_cap_r     <= EDGE_CAP_RST; // R15
			pin_function_r <= 1'b0;
			digit_low_r    <= DIGIT_RST; // R16
			digit_high_r   <= DIGIT_RST;
		end
		else if (wr_data)
		begin
			if (wr_idx_r == IDX_EDGE_CAPTURE)
				edge_cap_r <= hwdata[2:0]; // R15
			if (wr_idx_r == IDX_PIN_FUNCTION)
				pin_function_r <= hwdata[0];
			if (wr_idx_r == IDX_DIGIT_LOW)
				digit_low_r <= hwdata[3:0]; // R16
			if (wr_idx_r == IDX_DIGIT_HIGH)
				digit_high_r <= hwdata[3:0]; // R16
		end
	end

	assign upper_write   = wr_data & (wr_idx_r == IDX_DIGIT_HIGH);
	assign capture_enter = wr_data & (wr_idx_r == IDX_EDGE_CAPTURE) & hwdata[EC_CAPTURE_BIT] & ~capture_on;
	assign capture_on    = edge_cap_r[EC_CAPTURE_BIT];

	// ----------------------------------------------------------------
	// Prescaler: free-running divider, one-cycle tick per period
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			presc_r <= 11'h000;
		else
			presc_r <= presc_r + 11'h001;
	end

	// Period lookup for the low three clock mode bits
	always_comb
	begin
		unique case (clock_mode_r[2:0])
			3'h0:    period_m1 = PERIOD_M1_0; // R13
			3'h1:    period_m1 = PERIOD_M1_1;
			3'h2:    period_m1 = PERIOD_M1_2;
			3'h3:    period_m1 = PERIOD_M1_3;
			3'h4:    period_m1 = PERIOD_M1_4;
			3'h5:    period_m1 = PERIOD_M1_5;
			3'h6:    period_m1 = PERIOD_M1_6;
			default: period_m1 = PERIOD_M1_6; // External source, tick unused
		endcase
	end

	assign presc_tick = (presc_r & period_m1) == period_m1; // R13

	// ----------------------------------------------------------------
	// Event pin: three-stage synchroniser and edge detect
	// ----------------------------------------------------------------
	// A change is taken once stages two and three agree, which also
	// rejects a single-cycle glitch; only stage two reads stage one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_sync_r  <= 3'h0;
			pin_level_r <= 1'b0;
		end
		else
		begin
			pin_sync_r <= {pin_sync_r[1:0], event_trigger_pin}; // R19
			if (pin_sync_r[1] == pin_sync_r[2])
				pin_level_r <= pin_sync_r[2]; // R19
		end
	end

	assign pin_rise = (pin_sync_r[1] == pin_sync_r[2]) & pin_sync_r[2] & ~pin_level_r; // R19
	assign pin_fall = (pin_sync_r[1] == pin_sync_r[2]) & ~pin_sync_r[2] & pin_level_r; // R19

	// Configured edge kind; both-edge use relies on edges two cycles apart
	always_comb
	begin
		unique case (edge_cap_r[1:0])
			EDGE_NONE:    pin_edge = 1'b0;
			EDGE_FALLING: pin_edge = pin_fall; // R05
			EDGE_RISING:  pin_edge = pin_rise; // R05
			EDGE_BOTH:    pin_edge = pin_rise | pin_fall; // R05 R06
		endcase
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// External source only counts once the pin is given to the timer.
	// In capture mode the pin is the trigger, not a count source.
	assign ext_source  = clock_mode_r[2:0] == SRC_EXTERNAL;
	assign count_tick  = ext_source ? (pin_function_r & pin_edge & ~capture_on) : presc_tick; // R04 R05
	assign overflow    = count_tick & (count_r == COUNT_MAX); // R02
	assign capture_evt = capture_on & pin_function_r & pin_edge; // R07
	assign cap_err_evt = capture_on & ((capture_evt & capture_status_flag_r) | overflow); // R08

	// Priority: upper write, then entering capture, then trigger, then count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_r <= COUNT_ZERO;
		else if (upper_write)
			count_r <= {hwdata[3:0], digit_low_r}; // R18 R01
		else if (capture_enter)
			count_r <= COUNT_ZERO; // R10
		else if (capture_evt)
			count_r <= COUNT_ZERO; // R07
		else if (overflow)
			count_r <= clock_mode_r[CM_RELOAD_BIT] ? {digit_high_r, digit_low_r} : COUNT_ZERO; // R02 R14
		else if (count_tick)
			count_r <= count_r + 8'h01; // R01
	end

	// Captured value holds until the next trigger
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			capture_r <= COUNT_ZERO;
		else if (capture_evt)
			capture_r <= count_r; // R07
	end

	// ----------------------------------------------------------------
	// Timer flags: set wins over a software clear in the same cycle
	// ----------------------------------------------------------------
	// Writing zero to a flag bit clears it; writing one leaves it alone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			timer_irq_flag_r      <= 1'b0;
			capture_status_flag_r <= 1'b0; // R09
			capture_error_flag_r  <= 1'b0; // R09
		end
		else
		begin
			if (overflow || capture_evt)
				timer_irq_flag_r <= 1'b1; // R03 R07
			else if (wr_data && wr_idx_r == IDX_FLAGS && !hwdata[FLAG_IRQ_BIT])
				timer_irq_flag_r <= 1'b0; // R03
			if (capture_evt)
				capture_status_flag_r <= 1'b1; // R07
			else if (wr_data && wr_idx_r == IDX_FLAGS && !hwdata[FLAG_CSF_BIT])
				capture_status_flag_r <= 1'b0; // R09
			if (cap_err_evt)
				capture_error_flag_r <= 1'b1; // R08
			else if (wr_data && wr_idx_r == IDX_FLAGS && !hwdata[FLAG_CEF_BIT])
				capture_error_flag_r <= 1'b0; // R09
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status (clear on read), mask, and output
	// ----------------------------------------------------------------
	assign events = {cap_err_evt, capture_evt, overflow};

	// Per-event sticky bit; an event in the reading cycle survives
	for (genvar i = 0; i < 3; i++)
	begin : g_int
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
				int_status_r[i] <= 1'b0;
			else if (events[i])
				int_status_r[i] <= 1'b1;
			else if (int_read)
				int_status_r[i] <= 1'b0;
		end
	end

	// Mask: a one lets the matching status bit reach irq
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			int_mask_r <= 3'h0;
		else if (wr_data && wr_idx_r == IDX_INT_MASK)
			int_mask_r <= hwdata[2:0];
	end

	assign irq = |(int_status_r & int_mask_r);

endmodule // tdcc_timer

/* File: dv/tdcc_asserts.sv */
/* Port checker for the timer slave.
   Assumes it is bound into tdcc_timer with hready tied to hreadyout. */
`timescale 1ns/1ps
module tdcc_asserts
	import tdcc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        event_trigger_pin,
	input wire logic        irq
);
	// Taken requests and their register index
	wire logic       rd = hsel & hready & htrans[1] & !hwrite;
	wire logic       wr = hsel & hready & htrans[1] & hwrite;
	wire logic [7:0] ix = haddr[9:2];
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_always: assert property (hreadyout) else $error("ready low");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_holds: assert property (!$past(rd) |-> $stable(hrdata)) else $error("read data moved");
	a_reset_quiet: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !irq)
		else $error("outputs busy after reset");
	a_mode_reads_zero: assert property (rd && (ix == IDX_CLOCK_MODE || ix == IDX_EDGE_CAPTURE)
		|=> hrdata == 32'h0) else $error("write-only register read back");
	a_unmapped_zero: assert property (rd && ix == 8'h30 |=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_mask_blocks: assert property ((wr && ix == IDX_INT_MASK) ##1 hwdata[2:0] == 3'h0 |=> !irq)
		else $error("masked interrupt raised");
	// Read taken back to back after the write lands must return the new mask
	property p_mask_back;
		logic [2:0] v;
		(wr && ix == IDX_INT_MASK) ##1 (1'b1, v = hwdata[2:0]) ##1 (rd && ix == IDX_INT_MASK) |=> hrdata[2:0] == v;
	endproperty
	a_mask_readback: assert property (p_mask_back) else $error("mask readback wrong");
	c_irq: cover property ($rose(irq));
	c_capture_on: cover property ((wr && ix == IDX_EDGE_CAPTURE) ##1 hwdata[2]);
	c_pin_fall: cover property ($fell(event_trigger_pin));
endmodule // tdcc_asserts

bind tdcc_timer tdcc_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .event_trigger_pin(event_trigger_pin), .irq(irq));

/* File: dv/tdcc_evsrc.sv */
/* Source model for the event and trigger pin.
   Assumes calls are made just after a rising edge of hclk. */
`timescale 1ns/1ps
module tdcc_evsrc
(
	input wire logic hclk,
	output logic     pin
);
	initial pin = 1'b1;
	// Hold each level two cycles at least so edges never crowd together
	task automatic drive(input logic lvl, input int hold);
		pin <= lvl;
		repeat ((hold < 2) ? 2 : hold) @(posedge hclk);
	endtask
endmodule // tdcc_evsrc

/* File: dv/testbench.sv */
/* Bench for the timer: reset values, overflow, event counting, capture.
   Assumes the checker is bound in and the pin model is compiled. */
`timescale 1ns/1ps
module testbench
	import tdcc_pkg::*;
;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        irq;
	logic        pin;
	logic [31:0] rv;
	logic [31:0] hv;
	logic [7:0]  cap;
	int          fails      = 0;
	int          n_compared = 0;
	// Rows: register index, read data expected after reset
	localparam logic [11:0] ROWS [9] = '{12'h180, 12'h190, 12'h1A0, 12'h1B0, 12'h200,
		12'h210, 12'h220, 12'h230, 12'h300};
	// Rows: prescaler period in cycles for clock codes 0 to 5
	localparam int PERIODS [6] = '{2048, 512, 128, 32, 8, 4};

	always #2.5 hclk = ~hclk;

	tdcc_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.event_trigger_pin(pin), .irq(irq));
	tdcc_evsrc src (.hclk(hclk), .pin(pin));

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask

	// One word transfer; each phase waits for hready under a bound
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		for (int p = 0; p < 2; p++)
		begin
			n = 0;
			do
			begin
				@(posedge hclk);
				n++;
			end
			while (hready !== 1'b1 && n < 20);
			if (n >= 20)
			begin
				fails++;
				summarize();
			end
			if (p == 0)
			begin
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
		rv = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rdm(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, idx, 32'h0);
		chk(rv & m, e);
	endtask

	// One falling then one rising edge, four cycles apart
	task automatic pulse();
		src.drive(1'b0, 4);
		src.drive(1'b1, 4);
	endtask

	task automatic waitirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 100)
		begin
			@(posedge hclk);
			n++;
		end
		// A wait that runs out ends the run as a mismatch
		if (n >= 100)
		begin
			fails++;
			summarize();
		end
		chk({31'h0, irq}, 32'h1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 9; i++)
			rdm(ROWS[i][11:4], 32'hFFFFFFFF, {28'h0, ROWS[i][3:0]});
		$display("test reset values done");
		// Reload from FD keeps the upper digit at F; mask is read back to back
		wr(IDX_INT_MASK, 32'h1);
		rdm(IDX_INT_MASK, 32'h7, 32'h1);
		wr(IDX_CLOCK_MODE, 32'hE);
		repeat (2) @(posedge hclk);
		wr(IDX_DIGIT_LOW, 32'hD);
		wr(IDX_DIGIT_HIGH, 32'hF);
		waitirq();
		rdm(IDX_DIGIT_HIGH, 32'hF, 32'hF);
		rdm(IDX_FLAGS, 32'h1, 32'h1);
		// Free-running: FD wraps to zero
		wr(IDX_CLOCK_MODE, 32'h6);
		repeat (2) @(posedge hclk);
		wr(IDX_DIGIT_HIGH, 32'hF);
		repeat (12) @(posedge hclk);
		rdm(IDX_DIGIT_HIGH, 32'hF, 32'h0);
		wr(IDX_INT_MASK, 32'h0);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		$display("test overflow done");
		// Clock codes 0 to 5 each give exactly four ticks in four periods
		wr(IDX_DIGIT_LOW, 32'h0);
		for (int c = 0; c < 6; c++)
		begin
			wr(IDX_CLOCK_MODE, c);
			repeat (2) @(posedge hclk);
			wr(IDX_DIGIT_HIGH, 32'h0);
			repeat (4 * PERIODS[c]) @(posedge hclk);
			rdm(IDX_DIGIT_LOW, 32'hF, 32'h4);
		end
		$display("test prescaler done");
		// Three pulses for each edge code
		wr(IDX_PIN_FUNCTION, 32'h1);
		wr(IDX_CLOCK_MODE, 32'h7);
		wr(IDX_DIGIT_LOW, 32'h0);
		for (int e = 0; e < 4; e++)
		begin
			wr(IDX_EDGE_CAPTURE, e);
			wr(IDX_DIGIT_HIGH, 32'h0);
			repeat (3) pulse();
			repeat (6) @(posedge hclk);
			rdm(IDX_DIGIT_LOW, 32'hF, (e == 3) ? 32'h6 : (e == 0) ? 32'h0 : 32'h3);
		end
		$display("test event count done");
		// Capture on falling edges, 42 cycles apart at two cycles a tick
		wr(IDX_CLOCK_MODE, 32'h6);
		wr(IDX_EDGE_CAPTURE, 32'h5);
		wr(IDX_INT_MASK, 32'h6);
		wr(IDX_FLAGS, 32'h0);
		@(posedge hclk);
		rdm(IDX_FLAGS, 32'h7, 32'h0);
		pulse();
		rdm(IDX_FLAGS, 32'h7, 32'h3);
		// First capture counts from the clear on entering capture, not from six
		xfer(1'b0, IDX_DIGIT_LOW, 32'h0);
		cap[3:0] = rv[3:0];
		xfer(1'b0, IDX_DIGIT_HIGH, 32'h0);
		cap[7:4] = rv[3:0];
		chk(32'(cap inside {[8'h03:8'h07]}), 32'h1);
		wr(IDX_FLAGS, 32'h0);
		src.drive(1'b1, 26);
		pulse();
		rdm(IDX_FLAGS, 32'h7, 32'h3);
		xfer(1'b0, IDX_DIGIT_HIGH, 32'h0);
		cap[7:4] = rv[3:0];
		xfer(1'b0, IDX_DIGIT_LOW, 32'h0);
		cap[3:0] = rv[3:0];
		chk(32'(cap inside {[8'h13:8'h17]}), 32'h1);
		xfer(1'b0, IDX_DIGIT_LOW, 32'h0);
		hv = rv;
		xfer(1'b0, IDX_DIGIT_HIGH, 32'h0);
		chk({24'h0, rv[3:0], hv[3:0]}, {24'h0, cap});
		pulse();
		rdm(IDX_FLAGS, 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h1);
		rdm(IDX_INT_STATUS, 32'h6, 32'h6);
		rdm(IDX_INT_STATUS, 32'h6, 32'h0);
		wr(IDX_FLAGS, 32'h0);
		@(posedge hclk);
		rdm(IDX_FLAGS, 32'h7, 32'h0);
		$display("test capture done");
		// Reset in mid-run with flags set
		pulse();
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdm(IDX_FLAGS, 32'h7, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test mid-run reset done");
		summarize();
	end
endmodule // testbench
